//--- logic/cim_top.sv
// Channel input matrix: APB registers, routing, protection masking and driver outputs.
//
// Summary of operation
// RULE1: Channel on via register bit or pin.
// RULE2: Reset leaves direct mode, assign-select clear.
// RULE3: Assign-select set means assigned mode.
// RULE4: Combine zero: register bit OR pin.
// RULE5: Combine one: register bit AND pin.
// RULE6: Pins act in every operating mode.
// RULE7: Direct mode: channel 0, drivers register-only.
// RULE8: Direct: pins 1-3 drive channels 1-3.
// RULE9: Assigned: pin1 ch0, pin2 ch1, pin3 rest.
// RULE10: Inverse current holds state, sets no fault.
// RULE11: Inverse current blocks protection shutdown.
// RULE12: LED mode bits for channels 2, 3.
// RULE13: Each driver: drive and diag-enable output.
// RULE14: Driver outputs rest low when idle.
// RULE15: Drivers on by bits or assigned pin3.
// RULE16: PWM gate also drives external drivers.
// RULE17: Diag selector can pick either driver.
// RULE18: Compat mode: enable and select lines.
// RULE19: Code 100 enable only; 101 both.
// RULE20: Open pin reads low, never switches.
// RULE21: Four output channels, numbered 0 to 3.
// RULE22: Decision re-evaluated every clock cycle.
`timescale 1ns/100ps
`include "cim_map.svh"
module cim_top (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic input_pin_1_in,
  input wire logic input_pin_2_in,
  input wire logic input_pin_3_in,
  input wire logic [3:0] inverse_current_in,
  input wire logic [3:0] overtemp_in,
  input wire logic [3:0] overcurrent_in,
  input wire logic [5:0] pwm_gate_in,
  output logic [3:0] channel_on_out,
  output logic [1:0] ext_drive_output_out,
  output logic [1:0] ext_diag_enable_output_out,
  output logic [1:0] led_mode_bits_out,
  output logic [2:0] sense_select_out
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Input pin synchroniser
  // ****************************************************************
  // Two stages so a pin edge never reaches the routing half-settled.
  logic [3:1] pin_meta_q;
  logic [3:1] pin_sync_q;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {input_pin_3_in, input_pin_2_in, input_pin_1_in}; // RULE6 RULE20
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [5:0] channel_on_bits_q;
  cim_pkg::cim_drive_mode_t input_assign_select_q;
  cim_pkg::cim_combine_t input_combine_select_q;
  logic compat_diag_mode_q;
  logic [1:0] led_mode_bits_q;
  logic [2:0] diag_source_select_q;
  logic [3:0] fault_q;
  logic [3:0] ch_q;
  logic [1:0] ext_q;

  logic wr_en;
  logic rd_en;
  logic addr_ok;

  function automatic logic reg_hit(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      `CIM_OFS_CHAN_ON, `CIM_OFS_INPUT_CFG, `CIM_OFS_HW_CFG,
      `CIM_OFS_DIAG_SEL, `CIM_OFS_STATUS, `CIM_OFS_FAULT: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // A write or read takes effect only at the edge that returns pready.
  assign addr_ok = reg_hit(paddr_in);
  assign wr_en = psel_in & penable_in & ~pready_out & pwrite_in & addr_ok;
  assign rd_en = psel_in & penable_in & ~pready_out & ~pwrite_in;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      channel_on_bits_q <= `CIM_RST_CHAN_ON;
    end else if (wr_en && paddr_in == `CIM_OFS_CHAN_ON) begin
      channel_on_bits_q <= pwdata_in[`CIM_CHAN_ON_W-1:0]; // RULE1 RULE21
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      input_assign_select_q <= cim_pkg::CIM_DIRECT; // RULE2
      input_combine_select_q <= cim_pkg::CIM_COMBINE_OR;
      compat_diag_mode_q <= 1'b0;
    end else if (wr_en && paddr_in == `CIM_OFS_INPUT_CFG) begin
      input_assign_select_q <= cim_pkg::cim_drive_mode_t'(pwdata_in[`CIM_BIT_ASSIGN_SEL]); // RULE3
      input_combine_select_q <= cim_pkg::cim_combine_t'(pwdata_in[`CIM_BIT_COMBINE_SEL]);
      compat_diag_mode_q <= pwdata_in[`CIM_BIT_COMPAT_DIAG];
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      led_mode_bits_q <= `CIM_RST_LED;
    end else if (wr_en && paddr_in == `CIM_OFS_HW_CFG) begin
      led_mode_bits_q <= pwdata_in[`CIM_LED_W-1:0]; // RULE12
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      diag_source_select_q <= `CIM_RST_DIAG_SEL;
    end else if (wr_en && paddr_in == `CIM_OFS_DIAG_SEL) begin
      diag_source_select_q <= pwdata_in[`CIM_DIAG_W-1:0]; // RULE17
    end
  end

  // ****************************************************************
  // Protection faults
  // ****************************************************************
  // Sticky, cleared by writing one; a new fault in the clearing cycle wins.
  logic [3:0] fault_set;
  logic [3:0] fault_clr;

  assign fault_set = (overtemp_in | overcurrent_in) & ~inverse_current_in; // RULE10 RULE11
  assign fault_clr = (wr_en && paddr_in == `CIM_OFS_FAULT) ? pwdata_in[3:0] : 4'h0;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 4'h0;
    end else begin
      fault_q <= (fault_q & ~fault_clr) | fault_set;
    end
  end

  // ****************************************************************
  // Channel and driver decision
  // ****************************************************************
  logic [5:0] route_on;

  cim_route u_route (
    .channel_on_bits_in(channel_on_bits_q),
    .pin_in(pin_sync_q),
    .mode_in(input_assign_select_q),
    .combine_in(input_combine_select_q),
    .route_on_out(route_on)
  );

  // A channel under inverse current keeps its state; the load may look
  // faulty then, so its fault latch must not switch it off either.
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_chan
      always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
          ch_q[c] <= 1'b0;
        end else if (inverse_current_in[c]) begin
          ch_q[c] <= ch_q[c]; // RULE10
        end else begin
          ch_q[c] <= route_on[c] & pwm_gate_in[c] & ~fault_q[c]; // RULE22 RULE11
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 2'h0; // RULE14
    end else begin
      ext_q <= route_on[5:4] & pwm_gate_in[5:4]; // RULE15 RULE16 RULE13
    end
  end

  // ****************************************************************
  // Diagnosis enable outputs
  // ****************************************************************
  logic [1:0] diag_en_d;
  logic [1:0] diag_en_q;

  always_comb begin
    diag_en_d = 2'h0;
    if (compat_diag_mode_q) begin
      if (diag_source_select_q == `CIM_DIAG_EXT0) begin
        diag_en_d = 2'b01; // RULE18 RULE19
      end else if (diag_source_select_q == `CIM_DIAG_EXT1) begin
        diag_en_d = 2'b11; // RULE19
      end
    end else begin
      diag_en_d[0] = (diag_source_select_q == `CIM_DIAG_EXT0); // RULE17
      diag_en_d[1] = (diag_source_select_q == `CIM_DIAG_EXT1);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      diag_en_q <= 2'h0; // RULE14
    end else begin
      diag_en_q <= diag_en_d;
    end
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr_in)
      `CIM_OFS_CHAN_ON: begin
        rd_word[5:0] = channel_on_bits_q;
      end
      `CIM_OFS_INPUT_CFG: begin
        rd_word[`CIM_BIT_ASSIGN_SEL] = input_assign_select_q;
        rd_word[`CIM_BIT_COMBINE_SEL] = input_combine_select_q;
        rd_word[`CIM_BIT_COMPAT_DIAG] = compat_diag_mode_q;
      end
      `CIM_OFS_HW_CFG: begin
        rd_word[1:0] = led_mode_bits_q;
      end
      `CIM_OFS_DIAG_SEL: begin
        rd_word[2:0] = diag_source_select_q;
      end
      `CIM_OFS_STATUS: begin
        rd_word[5:0] = {ext_q, ch_q};
        rd_word[`CIM_STAT_INV_LSB+3:`CIM_STAT_INV_LSB] = inverse_current_in;
        rd_word[`CIM_STAT_SENSE_LSB+1:`CIM_STAT_SENSE_LSB] = diag_en_q;
      end
      `CIM_OFS_FAULT: begin
        rd_word[3:0] = fault_q;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // One wait state: pready rises on the second access cycle.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
      if (rd_en) begin
        prdata_out <= rd_word;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      led_mode_bits_out <= `CIM_RST_LED;
      sense_select_out <= `CIM_RST_DIAG_SEL;
    end else begin
      led_mode_bits_out <= led_mode_bits_q; // RULE12
      sense_select_out <= diag_source_select_q; // RULE17
    end
  end

  assign channel_on_out = ch_q;
  assign ext_drive_output_out = ext_q;
  assign ext_diag_enable_output_out = diag_en_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_pin1_direct_steady;
    (input_pin_1_in && input_assign_select_q == cim_pkg::CIM_DIRECT)[*3];
  endsequence

  sequence s_pin1_path_clear;
    !inverse_current_in[1] && !fault_q[1] && pwm_gate_in[1]
    && input_combine_select_q == cim_pkg::CIM_COMBINE_OR;
  endsequence

  a_pin1_drives_ch1: assert property ( // RULE8
    s_pin1_direct_steady ##0 s_pin1_path_clear |=> ch_q[1])
    else $error("pin 1 did not switch channel 1 on in direct mode");

  a_ch0_reg_only: assert property ( // RULE7
    (input_assign_select_q == cim_pkg::CIM_DIRECT && !inverse_current_in[0] && !fault_q[0])
    |=> ch_q[0] == ($past(channel_on_bits_q[0]) && $past(pwm_gate_in[0])))
    else $error("channel 0 did not follow its register bit in direct mode");

  a_gate_blocks_on: assert property ( // RULE5
    (input_combine_select_q == cim_pkg::CIM_COMBINE_GATE && !pin_sync_q[2]
     && input_assign_select_q == cim_pkg::CIM_DIRECT && !inverse_current_in[2])
    |=> !ch_q[2])
    else $error("channel 2 on while gated pin low");

  a_inv_holds_state: assert property ( // RULE10
    ((ch_q ^ $past(ch_q)) & $past(inverse_current_in)) == 4'h0)
    else $error("channel changed state under inverse current");

  a_inv_no_fault: assert property ( // RULE11
    ((fault_q & ~$past(fault_q)) & $past(inverse_current_in)) == 4'h0)
    else $error("fault latched during inverse current");

  a_fault_forces_off: assert property ( // RULE11
    (($past(fault_q) & ~$past(inverse_current_in)) & ch_q) == 4'h0)
    else $error("faulted channel stayed on");

  a_ext_assigned_pin3: assert property ( // RULE15
    (input_assign_select_q == cim_pkg::CIM_ASSIGNED && pin_sync_q[3] && pwm_gate_in[4]
     && input_combine_select_q == cim_pkg::CIM_COMBINE_OR)
    |=> ext_drive_output_out[0])
    else $error("pin 3 did not switch driver 0 on in assigned mode");

  a_compat_ext0: assert property ( // RULE19
    (compat_diag_mode_q && diag_source_select_q == `CIM_DIAG_EXT0)
    |=> ext_diag_enable_output_out == 2'b01)
    else $error("compatible code 100 gave wrong enable and select");

  a_compat_ext1: assert property ( // RULE19
    (compat_diag_mode_q && diag_source_select_q == `CIM_DIAG_EXT1)
    |=> ext_diag_enable_output_out == 2'b11)
    else $error("compatible code 101 gave wrong enable and select");

  a_reset_direct: assert property ( // RULE2
    $rose(rst_n) |-> input_assign_select_q == cim_pkg::CIM_DIRECT ##1 !ext_q[0])
    else $error("routing not in direct mode after reset");

endmodule

//--- shared/cim_map.svh
// Register offsets, field positions and reset values of the channel input matrix.
`ifndef CIM_MAP_SVH
`define CIM_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CIM_OFS_CHAN_ON 8'h00
`define CIM_OFS_INPUT_CFG 8'h04
`define CIM_OFS_HW_CFG 8'h08
`define CIM_OFS_DIAG_SEL 8'h0c
`define CIM_OFS_STATUS 8'h10
`define CIM_OFS_FAULT 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CIM_CHAN_ON_W 6
`define CIM_BIT_ASSIGN_SEL 0
`define CIM_BIT_COMBINE_SEL 1
`define CIM_BIT_COMPAT_DIAG 2
`define CIM_LED_W 2
`define CIM_DIAG_W 3
`define CIM_STAT_INV_LSB 8
`define CIM_STAT_SENSE_LSB 12

// ****************************************************************
// Reset values and decodes
// ****************************************************************
`define CIM_RST_CHAN_ON 6'h00
`define CIM_RST_LED 2'h0
`define CIM_RST_DIAG_SEL 3'h0
`define CIM_DIAG_EXT0 3'h4
`define CIM_DIAG_EXT1 3'h5

`endif

//--- shared/cim_pkg.sv
// Types shared by the channel input matrix modules.
package cim_pkg;

  typedef enum logic {
    CIM_DIRECT = 1'b0,
    CIM_ASSIGNED = 1'b1
  } cim_drive_mode_t;

  typedef enum logic {
    CIM_COMBINE_OR = 1'b0,
    CIM_COMBINE_GATE = 1'b1
  } cim_combine_t;

endpackage

//--- logic/cim_route.sv
// Input-to-channel routing and register/pin combining for the channel input matrix.
`timescale 1ns/100ps
module cim_route (
  input wire logic [5:0] channel_on_bits_in,
  input wire logic [3:1] pin_in,
  input wire cim_pkg::cim_drive_mode_t mode_in,
  input wire cim_pkg::cim_combine_t combine_in,
  output logic [5:0] route_on_out
);

  // Index 0 means no pin drives this output in the given mode.
  function automatic logic [1:0] pin_for(input int unsigned idx,
                                         input cim_pkg::cim_drive_mode_t mode);
    logic [1:0] sel;
    sel = 2'd0;
    if (mode == cim_pkg::CIM_DIRECT) begin
      if (idx >= 1 && idx <= 3) begin
        sel = 2'(idx); // RULE8
      end
    end else begin
      if (idx == 0) begin
        sel = 2'd1; // RULE9
      end else if (idx == 1) begin
        sel = 2'd2; // RULE9
      end else begin
        sel = 2'd3; // RULE9 RULE15
      end
    end
    return sel;
  endfunction

  function automatic logic pin_level(input logic [1:0] sel, input logic [3:1] pins);
    logic lvl;
    lvl = 1'b0;
    if (sel != 2'd0) begin
      lvl = pins[sel];
    end
    return lvl;
  endfunction

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_route
      logic [1:0] sel;
      assign sel = pin_for(g, mode_in);
      always_comb begin
        if (sel == 2'd0) begin
          route_on_out[g] = channel_on_bits_in[g]; // RULE7
        end else if (combine_in == cim_pkg::CIM_COMBINE_OR) begin
          route_on_out[g] = channel_on_bits_in[g] | pin_level(sel, pin_in); // RULE4 RULE1
        end else begin
          route_on_out[g] = channel_on_bits_in[g] & pin_level(sel, pin_in); // RULE5
        end
      end
    end
  endgenerate

endmodule

//--- test/cim_far_side.sv
// Model of the host pin drivers and the two external smart drivers.
`timescale 1ns/100ps
module cim_far_side (
  input wire logic [3:1] pin_level_in,
  input wire logic [3:1] pin_connected_in,
  input wire logic [1:0] ext_drive_output_in,
  output logic [3:1] pin_out,
  output logic [1:0] ext_load_on_out
);
  // A pin left open is held at ground by the sink, so it can never switch a load.
  assign pin_out = pin_level_in & pin_connected_in;
  // The driver input is pulled down and follows only a high drive level.
  assign ext_load_on_out = ext_drive_output_in;
endmodule

//--- test/testbench.sv
// Self-checking testbench of the channel input matrix.
`timescale 1ns/100ps
`include "cim_map.svh"
module testbench;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:1] pin_level = 3'h0;
  logic [3:1] pin_conn = 3'h7;
  logic [3:1] pins;
  logic [3:0] inv_cur = 4'h0;
  logic [3:0] otemp = 4'h0;
  logic [3:0] ocur = 4'h0;
  logic [5:0] pwm_gate = 6'h3f;
  logic [3:0] chan_on;
  logic [1:0] ext_drive;
  logic [1:0] ext_load;
  logic [1:0] diag_en;
  logic [1:0] led;
  logic [2:0] sense_sel;
  logic [31:0] rdata;
  logic rerr;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  always #25 clock_in = ~clock_in;

  cim_top uut (.clock_in(clock_in), .arst_n_in(arst_n_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .input_pin_1_in(pins[1]),
    .input_pin_2_in(pins[2]), .input_pin_3_in(pins[3]), .inverse_current_in(inv_cur),
    .overtemp_in(otemp), .overcurrent_in(ocur), .pwm_gate_in(pwm_gate),
    .channel_on_out(chan_on), .ext_drive_output_out(ext_drive),
    .ext_diag_enable_output_out(diag_en), .led_mode_bits_out(led),
    .sense_select_out(sense_sel));

  cim_far_side partner (.pin_level_in(pin_level), .pin_connected_in(pin_conn),
    .ext_drive_output_in(ext_drive), .pin_out(pins), .ext_load_on_out(ext_load));

  // ****************************************************************
  // Bus cycles and comparisons
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      err_total++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clock_in);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait.
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
    check(32'(rerr), 32'h0);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] expv);
    apb(1'b0, addr, 32'h0);
    check(rdata, expv);
  endtask

  // Waits past the two-flop pin synchroniser and the output flop.
  task automatic outs(input logic [5:0] expv);
    repeat (4) @(posedge clock_in);
    check(32'({ext_load, chan_on}), 32'(expv));
  endtask

  task automatic test_done();
    $display("Counts: %0d comparisons, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      test_done();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [5:0] asg_exp [3];
    logic [2:0] codes [3];
    logic [1:0] dexp [2][3];
    asg_exp = '{6'h01, 6'h02, 6'h3c};
    codes = '{`CIM_DIAG_EXT0, `CIM_DIAG_EXT1, 3'h3};
    dexp = '{'{2'h1, 2'h2, 2'h0}, '{2'h1, 2'h3, 2'h0}};
    repeat (3) @(posedge clock_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rd(`CIM_OFS_INPUT_CFG, 32'h0);
    rd(`CIM_OFS_CHAN_ON, 32'h0);
    outs(6'h00);
    $display("Test reset finished");
    for (int i = 1; i <= 3; i++) begin
      pin_level <= 3'(1 << (i - 1));
      outs(6'(1 << i));
    end
    pin_level <= 3'h7;
    outs(6'h0e);
    pin_conn <= 3'h0;
    outs(6'h00);
    pin_conn <= 3'h7;
    pin_level <= 3'h0;
    wr(`CIM_OFS_CHAN_ON, 32'h3f);
    outs(6'h3f);
    wr(`CIM_OFS_CHAN_ON, 32'h0);
    $display("Test direct drive finished");
    wr(`CIM_OFS_INPUT_CFG, 32'h1);
    for (int i = 1; i <= 3; i++) begin
      pin_level <= 3'(1 << (i - 1));
      outs(asg_exp[i - 1]);
    end
    wr(`CIM_OFS_INPUT_CFG, 32'h0);
    outs(6'h08);
    $display("Test assigned drive finished");
    wr(`CIM_OFS_INPUT_CFG, 32'h2);
    wr(`CIM_OFS_CHAN_ON, 32'h0e);
    pin_level <= 3'h2;
    outs(6'h04);
    pin_level <= 3'h7;
    pwm_gate <= 6'h3b;
    outs(6'h0a);
    wr(`CIM_OFS_INPUT_CFG, 32'h0);
    wr(`CIM_OFS_CHAN_ON, 32'h34);
    pin_level <= 3'h0;
    pwm_gate <= 6'h1b;
    outs(6'h10);
    pwm_gate <= 6'h3f;
    $display("Test combine and gate finished");
    wr(`CIM_OFS_CHAN_ON, 32'h01);
    inv_cur <= 4'h3;
    outs(6'h01);
    rd(`CIM_OFS_STATUS, 32'h301);
    wr(`CIM_OFS_CHAN_ON, 32'h02);
    otemp <= 4'h1;
    ocur <= 4'h2;
    outs(6'h01);
    rd(`CIM_OFS_FAULT, 32'h0);
    otemp <= 4'h0;
    ocur <= 4'h0;
    outs(6'h01);
    inv_cur <= 4'h0;
    outs(6'h02);
    ocur <= 4'h2;
    outs(6'h00);
    rd(`CIM_OFS_FAULT, 32'h2);
    ocur <= 4'h0;
    wr(`CIM_OFS_FAULT, 32'h2);
    outs(6'h02);
    $display("Test inverse current finished");
    wr(`CIM_OFS_HW_CFG, 32'h2);
    repeat (2) @(posedge clock_in);
    check(32'(led), 32'h2);
    wr(`CIM_OFS_HW_CFG, 32'h1);
    repeat (2) @(posedge clock_in);
    check(32'(led), 32'h1);
    rd(`CIM_OFS_HW_CFG, 32'h1);
    for (int c = 0; c < 2; c++) begin
      wr(`CIM_OFS_INPUT_CFG, 32'(c << `CIM_BIT_COMPAT_DIAG));
      for (int k = 0; k < 3; k++) begin
        wr(`CIM_OFS_DIAG_SEL, 32'(codes[k]));
        repeat (2) @(posedge clock_in);
        check(32'(sense_sel), 32'(codes[k]));
        check(32'(diag_en), 32'(dexp[c][k]));
      end
    end
    $display("Test diagnosis finished");
    wr(`CIM_OFS_INPUT_CFG, 32'h1);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rd(`CIM_OFS_INPUT_CFG, 32'h0);
    outs(6'h00);
    $display("Test second reset finished");
    apb(1'b1, 8'h20, 32'hffffffff);
    check(32'(rerr), 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check(rdata, 32'h0);
    check(32'(rerr), 32'h1);
    $display("Test unmapped access finished");
    test_done();
  end
endmodule
